// ==== verilog/oats_pkg.sv ====
`default_nettype none
package oats_pkg;
    // ==========================================================
    // clock
    localparam int CLK_PERIOD_NS = 10;

    // ==========================================================
    // command bytes (first, second, third control byte)
    localparam int CMD_BITS = 24;
    localparam logic [7:0] OP_ODD_PIXEL_ZEBRA_TEST = 8'hE8;
    localparam logic [7:0] OP_EVEN_PIXEL_ZEBRA_TEST = 8'hE4;
    localparam logic [7:0] OP_ALL_PIXEL_ZEBRA_TEST = 8'hE2;
    localparam logic [7:0] OP_NULL_ZEBRA_TEST = 8'hE1;
    localparam logic [7:0] OP_SLEEP_COMMAND = 8'hC6;
    localparam logic [7:0] OP_WAKE_COMMAND = 8'hC3;
    localparam logic [7:0] OP_CHIP_RESET_COMMAND = 8'hF0;
    localparam logic [15:0] CMD_ZERO_TAIL = 16'h0000;

    // ==========================================================
    // pixels
    localparam logic [7:0] PIXEL_FIRST = 8'h01;
    localparam logic [7:0] PIXEL_LAST = 8'h90;

    // ==========================================================
    // timing
    localparam int FRAME_READY_DELAY_NS = 200000;
    localparam int FRAME_READY_DELAY_CYCLES = (FRAME_READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_TIME_NS = 500000;
    localparam int WAKE_TIME_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COUNT_W = 32;

    // ==========================================================
    // checksum
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_CLEAR_VALUE = 16'h0000;
    localparam logic [7:0] CRC_INIT_BYTE = 8'hFF;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [2:0] {
        PAT_NONE = 3'b000,
        PAT_ODD = 3'b001,
        PAT_EVEN = 3'b010,
        PAT_ALL = 3'b011,
        PAT_NULL = 3'b100
    } oats_pattern_type;

    typedef enum logic [1:0] {
        ZB_IDLE = 2'b00,
        ZB_INTEG = 2'b01,
        ZB_READY = 2'b10
    } oats_zebra_type;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_DATA = 2'b01,
        FR_CRC1 = 2'b10,
        FR_CRC2 = 2'b11
    } oats_frame_type;

    // one byte into the checksum register, most significant bit first
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ==== verilog/oats_sensor_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// - 0xE8,0,0 selects odd-pixel zebra test
// - odd test: odd pixels high, even low
// - 0xE4,0,0: odd pixels low, even high
// - even test: zebra pixel 1 reads low
// - 0xE2,0,0: all 144 pixels high
// - 0xE1: all 144 pixels read low
// - null test: temperature byte reads dark
// - zebra integration starts on chip select high
// - fixed time, frame-ready after fixed delay
// - zebra frame read like integration frame
// - 0xC6,0,0 sleeps analog, oscillator, ADC; code drops only analogEnable and internalOscillatorEnable, no ADC enable
// - 0xC3,0,0 wakes; wait wake-up time
// - chip reset accepted always, recovery applies only when reset from sleep
// - 16-bit checksum over bytes 0..N-3 appended
// - polynomial x16 + x12 + x5 + 1
// - clear to zero, shift 0xFFFF first
// - first byte bits 16..9, second 8..1
// - rising frame-ready means read-out may start
module oats_sensor_ctrl #(
    parameter int FRAME_READY_CYCLES = oats_pkg::FRAME_READY_DELAY_CYCLES,
    parameter int WAKE_CYCLES = oats_pkg::WAKE_TIME_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic chipSelectN,
    input wire logic spiClk,
    input wire logic spiMosi,
    input wire logic readOutStart,
    input wire logic [7:0] pixelIndex,
    output logic pixelHigh,
    output logic temperatureDark,
    output logic frameDoneFlag,
    output logic analogEnable,
    output logic internalOscillatorEnable,
    output logic wakeBusy,
    output logic chipResetPulse,
    output oats_pkg::oats_pattern_type activePattern,
    input wire logic frameInValid,
    input wire logic [7:0] frameInData,
    input wire logic frameInLast,
    output logic frameInReady,
    output logic frameOutValid,
    output logic [7:0] frameOutData,
    input wire logic frameOutReady
);
    import oats_pkg::*;

    // ==========================================================
    // pin synchronisers and command shifter
    logic csSync1_q, csSync_q, csPrev_q;
    logic sclkSync1_q, sclkSync_q, sclkPrev_q;
    logic mosiSync1_q, mosiSync_q;
    logic [CMD_BITS-1:0] shift_q, shift_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic csRise, sclkRise, cmdTaken;
    logic [7:0] opByte;

    assign csRise = csSync_q & ~csPrev_q;
    assign sclkRise = sclkSync_q & ~sclkPrev_q;
    assign opByte = shift_q[23:16];
    assign cmdTaken = csRise && (bitCnt_q == 5'(CMD_BITS)) && (shift_q[15:0] == CMD_ZERO_TAIL);

    always_comb begin
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        if (csSync_q) begin
            if (csRise) begin
                bitCnt_d = 5'h00;
            end
        end else if (sclkRise) begin
            shift_d = {shift_q[CMD_BITS-2:0], mosiSync_q};
            if (bitCnt_q != 5'h1F) begin
                bitCnt_d = bitCnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            csSync1_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
            sclkSync1_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            mosiSync1_q <= 1'b0;
            mosiSync_q <= 1'b0;
            shift_q <= 24'h000000;
            bitCnt_q <= 5'h00;
        end else begin
            csSync1_q <= chipSelectN;
            csSync_q <= csSync1_q;
            csPrev_q <= csSync_q;
            sclkSync1_q <= spiClk;
            sclkSync_q <= sclkSync1_q;
            sclkPrev_q <= sclkSync_q;
            mosiSync1_q <= spiMosi;
            mosiSync_q <= mosiSync1_q;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
        end
    end

    // ==========================================================
    // command execution: zebra, sleep, wake, chip reset
    oats_zebra_type zState_q, zState_d;
    oats_pattern_type pattern_q, pattern_d;
    logic [COUNT_W-1:0] zCnt_q, zCnt_d, wCnt_q, wCnt_d;
    logic sleep_q, sleep_d;
    logic isZebra, isSleep, isWake, isReset;
    oats_pattern_type decoded;

    always_comb begin
        decoded = PAT_NONE;
        case (opByte)
            OP_ODD_PIXEL_ZEBRA_TEST: decoded = PAT_ODD;
            OP_EVEN_PIXEL_ZEBRA_TEST: decoded = PAT_EVEN;
            OP_ALL_PIXEL_ZEBRA_TEST: decoded = PAT_ALL;
            OP_NULL_ZEBRA_TEST: decoded = PAT_NULL;
            default: decoded = PAT_NONE;
        endcase
    end

    assign isZebra = cmdTaken && (decoded != PAT_NONE) && !sleep_q && (wCnt_q == '0);
    assign isSleep = cmdTaken && (opByte == OP_SLEEP_COMMAND);
    assign isWake = cmdTaken && (opByte == OP_WAKE_COMMAND) && sleep_q;
    assign isReset = cmdTaken && (opByte == OP_CHIP_RESET_COMMAND);

    always_comb begin
        zState_d = zState_q;
        pattern_d = pattern_q;
        zCnt_d = zCnt_q;
        sleep_d = sleep_q;
        wCnt_d = (wCnt_q != '0) ? wCnt_q - 1'b1 : wCnt_q;
        case (zState_q)
            ZB_INTEG: begin
                if (zCnt_q <= COUNT_W'(1)) begin
                    zState_d = ZB_READY;
                end else begin
                    zCnt_d = zCnt_q - 1'b1;
                end
            end
            ZB_READY: begin
                if (readOutStart) begin
                    zState_d = ZB_IDLE;
                end
            end
            ZB_IDLE: zState_d = ZB_IDLE;
            default: zState_d = ZB_IDLE;
        endcase
        if (isZebra) begin
            zState_d = ZB_INTEG;
            pattern_d = decoded;
            zCnt_d = COUNT_W'(FRAME_READY_CYCLES);
        end
        if (isSleep) begin
            sleep_d = 1'b1;
            zState_d = ZB_IDLE;
        end
        if (isWake || (isReset && sleep_q)) begin
            sleep_d = 1'b0;
            wCnt_d = COUNT_W'(WAKE_CYCLES);
        end
        if (isReset) begin
            zState_d = ZB_IDLE;
            pattern_d = PAT_NONE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            zState_q <= ZB_IDLE;
            pattern_q <= PAT_NONE;
            zCnt_q <= '0;
            wCnt_q <= '0;
            sleep_q <= 1'b0;
        end else begin
            zState_q <= zState_d;
            pattern_q <= pattern_d;
            zCnt_q <= zCnt_d;
            wCnt_q <= wCnt_d;
            sleep_q <= sleep_d;
        end
    end

    // ==========================================================
    // registered outputs: flags and test pixel levels
    logic pixHigh_q, pixHigh_d, tempDark_q, rstPulse_q, done_q;

    always_comb begin
        pixHigh_d = 1'b0;
        if (pixelIndex >= PIXEL_FIRST && pixelIndex <= PIXEL_LAST) begin
            case (pattern_q)
                PAT_ODD: pixHigh_d = pixelIndex[0];
                PAT_EVEN: pixHigh_d = ~pixelIndex[0];
                PAT_ALL: pixHigh_d = 1'b1;
                PAT_NULL: pixHigh_d = 1'b0;
                PAT_NONE: pixHigh_d = 1'b0;
                default: pixHigh_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pixHigh_q <= 1'b0;
            tempDark_q <= 1'b0;
            rstPulse_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            pixHigh_q <= pixHigh_d;
            tempDark_q <= (pattern_d == PAT_NULL);
            rstPulse_q <= isReset;
            done_q <= (zState_d == ZB_READY);
        end
    end

    assign pixelHigh = pixHigh_q;
    assign temperatureDark = tempDark_q;
    assign frameDoneFlag = done_q;
    assign analogEnable = ~sleep_q;
    assign internalOscillatorEnable = ~sleep_q;
    assign wakeBusy = (wCnt_q != '0);
    assign chipResetPulse = rstPulse_q;
    assign activePattern = pattern_q;

    // ==========================================================
    // frame checksum and two-entry output buffer
    oats_frame_type fState_q, fState_d;
    logic [15:0] crc_q, crc_d, crcSeed;
    logic [7:0] bufMem_q [BUF_DEPTH];
    logic rdPtr_q, wrPtr_q;
    logic [1:0] count_q;
    logic pushValid, push, pop;
    logic [7:0] pushData;

    assign crcSeed = crcByte(crcByte(CRC_CLEAR_VALUE, CRC_INIT_BYTE), CRC_INIT_BYTE);
    assign frameInReady = (count_q != 2'(BUF_DEPTH)) && (fState_q == FR_IDLE || fState_q == FR_DATA);
    assign pop = frameOutValid && frameOutReady;
    assign push = pushValid && (count_q != 2'(BUF_DEPTH));

    always_comb begin
        fState_d = fState_q;
        crc_d = crc_q;
        pushValid = 1'b0;
        pushData = frameInData;
        case (fState_q)
            FR_IDLE, FR_DATA: begin
                pushValid = frameInValid;
                if (frameInValid && frameInReady) begin
                    crc_d = crcByte((fState_q == FR_IDLE) ? crcSeed : crc_q, frameInData);
                    fState_d = frameInLast ? FR_CRC1 : FR_DATA;
                end
            end
            FR_CRC1: begin
                pushValid = 1'b1;
                pushData = crc_q[15:8];
                if (push) begin
                    fState_d = FR_CRC2;
                end
            end
            FR_CRC2: begin
                pushValid = 1'b1;
                pushData = crc_q[7:0];
                if (push) begin
                    fState_d = FR_IDLE;
                end
            end
            default: fState_d = FR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fState_q <= FR_IDLE;
            crc_q <= CRC_CLEAR_VALUE;
            bufMem_q[0] <= 8'h00;
            bufMem_q[1] <= 8'h00;
            rdPtr_q <= 1'b0;
            wrPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            fState_q <= fState_d;
            crc_q <= crc_d;
            if (push) begin
                bufMem_q[wrPtr_q] <= pushData;
                wrPtr_q <= ~wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= ~rdPtr_q;
            end
            count_q <= count_q + 2'(push) - 2'(pop);
        end
    end

    assign frameOutValid = (count_q != 2'h0);
    assign frameOutData = bufMem_q[rdPtr_q];

    // ==========================================================
    // checks
    // high checksum byte as it was pushed, for the self-check on the low byte
    logic [7:0] crcHi_q;
    logic [COUNT_W-1:0] sinceCs_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceCs_q <= '0;
            crcHi_q <= 8'h00;
        end else begin
            sinceCs_q <= isZebra ? COUNT_W'(1) : ((sinceCs_q != '0) ? sinceCs_q + 1'b1 : sinceCs_q);
            crcHi_q <= (fState_q == FR_CRC1 && push) ? pushData : crcHi_q;
        end
    end

    zebra_on_cs_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(zState_q == ZB_INTEG) |-> $past(csRise))
        else $error("zebra integration started without chip select rise");
    ready_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(frameDoneFlag) |-> (sinceCs_q == COUNT_W'(FRAME_READY_CYCLES + 1)))
        else $error("frame ready not at fixed delay");
    odd_level_a: assert property (@(posedge clk) disable iff (!reset_n)
        (pattern_q == PAT_ODD && $stable(pattern_q) && pixelIndex == 8'h8F) |=> pixelHigh)
        else $error("odd pixel not high in odd test");
    even_zebra_a: assert property (@(posedge clk) disable iff (!reset_n)
        (pattern_q == PAT_EVEN && $stable(pattern_q) && pixelIndex == PIXEL_FIRST) |=> !pixelHigh)
        else $error("zebra pixel high in even test");
    null_temp_a: assert property (@(posedge clk) disable iff (!reset_n)
        (pattern_q == PAT_NULL) |-> temperatureDark)
        else $error("temperature not dark in null test");
    sleep_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        isSleep |=> !analogEnable && !internalOscillatorEnable)
        else $error("analog still on after sleep");
    wake_busy_a: assert property (@(posedge clk) disable iff (!reset_n)
        isWake |=> wakeBusy [*8])
        else $error("wake time not applied");
    reset_sleep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (isReset && sleep_q) |=> analogEnable && wakeBusy && chipResetPulse)
        else $error("chip reset not taken in sleep");
    crc_order_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fState_q == FR_CRC2 && push) |-> (pushData == crc_q[7:0]) && $past(fState_q) != FR_IDLE)
        else $error("checksum byte order wrong");
    crc_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fState_q == FR_CRC2 && push) |-> (crcByte(crcByte(crc_q, crcHi_q), pushData) == CRC_CLEAR_VALUE))
        else $error("frame checksum check failed");
endmodule // oats_sensor_ctrl
`default_nettype wire

// ==== test/oats_spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================
// spi master standing in for the microcontroller
module oats_spi_host_model (
    input wire logic clk,
    output var logic chipSelectN,
    output var logic spiClk,
    output var logic spiMosi
);
    initial begin
        chipSelectN = 1'b1;
        spiClk = 1'b0;
        spiMosi = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // clock idles low outside frames, five clk per half period
    task automatic send(input logic [23:0] cmd, input int nBits);
        tick(1);
        chipSelectN = 1'b0;
        for (int i = 23; i > 23 - nBits; i--) begin
            spiMosi = cmd[i];
            tick(5);
            spiClk = 1'b1;
            tick(5);
            spiClk = 1'b0;
        end
        tick(5);
        chipSelectN = 1'b1;
        spiMosi = ~spiMosi;
    endtask
endmodule // oats_spi_host_model
`default_nettype wire

// ==== test/oats_sensor_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module oats_sensor_ctrl_tb_top;
    import oats_pkg::*;
    localparam int FR = 20;
    localparam int WK = 20;
    logic clk, reset_n, readOutStart, frameInValid, frameInLast, frameOutReady, frameInReady, frameOutValid;
    logic chipSelectN, spiClk, spiMosi, pixelHigh, temperatureDark, frameDoneFlag;
    logic analogEnable, internalOscillatorEnable, wakeBusy, chipResetPulse, hsSeen;
    logic [7:0] pixelIndex, frameInData, frameOutData, hsData;
    logic [7:0] outQ[$];
    oats_pattern_type activePattern;
    int nErrors = 0;
    int compares = 0;
    int cycles = 0;
    int crCount = 0;

    // ====================
    // clock, sink and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        hsSeen = frameOutValid === 1'b1 && frameOutReady === 1'b1;
        hsData = frameOutData;
    end
    always @(posedge clk) begin
        cycles++;
        if (chipResetPulse === 1'b1) crCount++;
        if (hsSeen) outQ.push_back(hsData);
        if (cycles > 20000) begin
            nErrors++;
            close_out();
        end
    end

    oats_spi_host_model oats_spi_host_model_i (.clk(clk), .chipSelectN(chipSelectN), .spiClk(spiClk),
        .spiMosi(spiMosi));
    oats_sensor_ctrl #(.FRAME_READY_CYCLES(FR), .WAKE_CYCLES(WK)) oats_sensor_ctrl_i (.clk(clk),
        .reset_n(reset_n), .chipSelectN(chipSelectN), .spiClk(spiClk), .spiMosi(spiMosi),
        .readOutStart(readOutStart), .pixelIndex(pixelIndex), .pixelHigh(pixelHigh),
        .temperatureDark(temperatureDark), .frameDoneFlag(frameDoneFlag), .analogEnable(analogEnable),
        .internalOscillatorEnable(internalOscillatorEnable), .wakeBusy(wakeBusy),
        .chipResetPulse(chipResetPulse), .activePattern(activePattern), .frameInValid(frameInValid),
        .frameInData(frameInData), .frameInLast(frameInLast), .frameInReady(frameInReady),
        .frameOutValid(frameOutValid), .frameOutData(frameOutData), .frameOutReady(frameOutReady));

    // ====================
    // helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [15:0] tail, input int nBits);
        oats_spi_host_model_i.send({op, tail}, nBits);
    endtask

    task automatic run_zebra(input logic [7:0] op, output int n);
        cmd(op, CMD_ZERO_TAIL, 24);
        n = 0;
        while (frameDoneFlag !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
    endtask

    task automatic wait_busy(output int n);
        int w;
        w = 0;
        while (wakeBusy !== 1'b1 && w < 50) begin
            tick(1);
            w++;
        end
        n = 0;
        while (wakeBusy === 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
    endtask

    task automatic push(input logic [7:0] d, input logic last);
        logic ok;
        frameInValid = 1'b1;
        frameInData = d;
        frameInLast = last;
        do begin
            @(negedge clk);
            ok = frameInReady === 1'b1;
            @(posedge clk);
        end while (!ok);
        #1;
    endtask

    function automatic logic expPx(input oats_pattern_type p, input int i);
        if (i < 1 || i > 144) return 1'b0;
        case (p)
            PAT_ODD: return i % 2 == 1;
            PAT_EVEN: return i % 2 == 0;
            PAT_ALL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] crcRef(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 7; b >= 0; b--) r = (r << 1) ^ ((r[15] ^ d[b]) ? 16'h1021 : 16'h0000);
        return r;
    endfunction

    // ====================
    // scenarios
    task automatic test_zebra;
        logic [7:0] ops [4];
        oats_pattern_type pats [4];
        int idx [6];
        int n;
        ops = '{OP_ODD_PIXEL_ZEBRA_TEST, OP_EVEN_PIXEL_ZEBRA_TEST, OP_ALL_PIXEL_ZEBRA_TEST, OP_NULL_ZEBRA_TEST};
        pats = '{PAT_ODD, PAT_EVEN, PAT_ALL, PAT_NULL};
        idx = '{0, 1, 2, 143, 144, 145};
        for (int k = 0; k < 4; k++) begin
            run_zebra(ops[k], n);
            chk(16'(n), 16'(FR + 3), "frame ready delay");
            chk(16'(activePattern), 16'(pats[k]), "pattern");
            chk(16'(temperatureDark), 16'(pats[k] == PAT_NULL), "temperature dark");
            foreach (idx[j]) begin
                pixelIndex = 8'(idx[j]);
                tick(2);
                chk(16'(pixelHigh), 16'(expPx(pats[k], idx[j])), "pixel level");
            end
            readOutStart = 1'b1;
            tick(1);
            readOutStart = 1'b0;
            tick(2);
            chk(16'(frameDoneFlag), 16'h0000, "flag after read-out");
        end
        $display("test_zebra done");
    endtask

    task automatic test_refuse;
        cmd(OP_ODD_PIXEL_ZEBRA_TEST, 16'h0100, 24);
        tick(FR + 10);
        chk(16'(frameDoneFlag), 16'h0000, "nonzero tail");
        cmd(OP_ALL_PIXEL_ZEBRA_TEST, CMD_ZERO_TAIL, 23);
        tick(FR + 10);
        chk(16'(frameDoneFlag), 16'h0000, "short command");
        $display("test_refuse done");
    endtask

    task automatic test_sleep;
        int n, c0;
        cmd(OP_SLEEP_COMMAND, CMD_ZERO_TAIL, 24);
        tick(5);
        chk(16'(analogEnable), 16'h0000, "analog off");
        chk(16'(internalOscillatorEnable), 16'h0000, "oscillator off");
        cmd(OP_ALL_PIXEL_ZEBRA_TEST, CMD_ZERO_TAIL, 24);
        tick(FR + 10);
        chk(16'(frameDoneFlag), 16'h0000, "zebra while asleep");
        cmd(OP_WAKE_COMMAND, CMD_ZERO_TAIL, 24);
        wait_busy(n);
        chk(16'(n), 16'(WK), "wake time");
        chk(16'(analogEnable), 16'h0001, "analog on");
        cmd(OP_WAKE_COMMAND, CMD_ZERO_TAIL, 24);
        tick(10);
        chk(16'(wakeBusy), 16'h0000, "wake while awake");
        cmd(OP_SLEEP_COMMAND, CMD_ZERO_TAIL, 24);
        tick(5);
        c0 = crCount;
        cmd(OP_CHIP_RESET_COMMAND, CMD_ZERO_TAIL, 24);
        wait_busy(n);
        chk(16'(n), 16'(WK), "recovery time");
        chk(16'(crCount - c0), 16'h0001, "reset pulse");
        chk(16'(internalOscillatorEnable), 16'h0001, "oscillator on");
        run_zebra(OP_ODD_PIXEL_ZEBRA_TEST, n);
        chk(16'(n), 16'(FR + 3), "zebra after recovery");
        $display("test_sleep done");
    endtask

    task automatic test_crc;
        logic [7:0] msg [9];
        logic [15:0] c;
        int w;
        msg = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
        outQ.delete();
        frameOutReady = 1'b0;
        push(msg[0], 1'b0);
        push(msg[1], 1'b0);
        @(negedge clk);
        chk(16'(frameInReady), 16'h0000, "full buffer refuses");
        tick(1);
        frameOutReady = 1'b1;
        for (int i = 2; i < 9; i++) push(msg[i], i == 8);
        frameInValid = 1'b0;
        w = 0;
        while (outQ.size() < 11 && w < 100) begin
            tick(1);
            w++;
        end
        chk(16'(outQ.size()), 16'h000B, "frame length");
        foreach (msg[i]) chk(16'(outQ[i]), 16'(msg[i]), "data byte");
        chk({outQ[9], outQ[10]}, 16'hE5CC, "checksum bytes");
        c = crcRef(crcRef(16'h0000, 8'hFF), 8'hFF);
        foreach (outQ[i]) c = crcRef(c, outQ[i]);
        chk(c, 16'h0000, "whole frame check");
        outQ.delete();
        push(8'h41, 1'b1);
        frameInValid = 1'b0;
        tick(10);
        chk({outQ[1], outQ[2]}, 16'h9479, "one byte checksum");
        $display("test_crc done");
    endtask

    initial begin
        reset_n = 1'b0;
        readOutStart = 1'b0;
        pixelIndex = 8'h00;
        frameInValid = 1'b0;
        frameInData = 8'h00;
        frameInLast = 1'b0;
        frameOutReady = 1'b1;
        tick(5);
        reset_n = 1'b1;
        tick(2);
        test_zebra();
        test_refuse();
        test_sleep();
        test_crc();
        close_out();
    end
endmodule // oats_sensor_ctrl_tb_top
`default_nettype wire
